// >>> rtl/vpmap_pkg.sv
// Package for the partition-id map register bank: register selectors, access outcomes and fields.
// Assumes a core that decodes system-register instructions into a selector and a privilege level.
package vpmap_pkg;
  localparam int unsigned VPMAP_DATA_W        = 64;
  localparam int unsigned VPMAP_ENTRY_W       = 16;
  localparam int unsigned VPMAP_ENTRIES_PER   = 4;
  localparam int unsigned VPMAP_MAX_REGS      = 8;
  localparam int unsigned VPMAP_NUM_VALID     = 32;
  localparam int unsigned VPMAP_VALID_W       = 32;
  localparam logic [2:0]  VPMAP_HIGHEST_INDEX = 3'h7;
  // Register selector: encoding op0,op1,CRn,CRm,op2 packed as 3,4,C10,C4/C6,op2.
  localparam logic [15:0] VPMAP_ENC_VALID     = 16'hE521;
  localparam logic [15:0] VPMAP_ENC_ENTRY0    = 16'hE530;
  localparam logic [15:0] VPMAP_ENC_ENTRY_MSK = 16'hFFF8;
  localparam logic [11:0] VPMAP_NV_OFS_VALID  = 12'h938;
  localparam logic [11:0] VPMAP_NV_OFS_ENTRY0 = 12'h940;
  localparam logic [11:0] VPMAP_NV_OFS_STEP   = 12'h008;
  localparam logic [5:0]  VPMAP_TRAP_CLASS    = 6'h18;
  localparam logic [1:0]  VPMAP_LEVEL0        = 2'h0;
  localparam logic [1:0]  VPMAP_LEVEL1        = 2'h1;
  localparam logic [1:0]  VPMAP_LEVEL2        = 2'h2;
  localparam logic [1:0]  VPMAP_LEVEL3        = 2'h3;

  typedef enum logic [3:0] {
    VPMAP_RES_DIRECT = 4'h1,
    VPMAP_RES_MEMORY = 4'h2,
    VPMAP_RES_TRAP   = 4'h4,
    VPMAP_RES_UNDEF  = 4'h8
  } vpmap_result_t;
endpackage

// >>> rtl/vpmap_lookup.sv
// Translates one virtual partition id through the map, used once per translated level.
// Assumes the map and valid flags are presented from flip-flops of the parent bank.
`timescale 1ns/100ps
module vpmap_lookup #(
  parameter int unsigned ENTRIES = 32,
  parameter int unsigned ID_W    = 16
) (
  input  wire logic [ID_W-1:0]         virt_id_i,
  input  wire logic                    map_enable_i,
  input  wire logic [ENTRIES*ID_W-1:0] map_i,
  input  wire logic [ENTRIES-1:0]      valid_i,
  input  wire logic [4:0]              implemented_i,
  output logic      [ID_W-1:0]         phys_id_o,
  output logic                         hit_o
);
  logic [4:0] idx;
  logic       in_range;
  always_comb begin
    idx      = virt_id_i[4:0];
    in_range = (virt_id_i < ID_W'(ENTRIES)) && (idx <= implemented_i);
    hit_o     = map_enable_i && in_range && valid_i[idx];
    phys_id_o = hit_o ? map_i[idx*ID_W +: ID_W] : virt_id_i;
  end
endmodule

// >>> rtl/vpmap_bank.sv
// Virtual-to-physical partition id map register bank with privilege-checked system-register access.
// Assumes the core presents one access per cycle and acts on the outcome the same cycle.
//
// How it works
// - valid bit m belongs to entry m, held in map register m>>2.
// - the valid register holds 32 flags in bits 31..0; upper bits read zero.
// - without level 2 enabled the bank has no effect on partition ids.
// - map register 0 holds translations for virtual ids 0 to 3.
// - a feature field reports the highest implemented map register index, at most 7.
// - with highest index zero only map register 0 exists.
// - level-1 and level-0 ids are mapped only when their enable is set.
// - an entry counts only while its valid bit is one.
// - any level-0 access is undefined.
// - level 1 with level 2 enabled and both nested controls set redirects to memory at 0x938 (valid register) or 0x940 + 8 x n (map register n).
// - level 1 with level 2 enabled and nested enable only traps class 0x18 to level 3 or 2, else undefined.
// - level 2 traps to level 3 under trap-lower, else accesses directly.
// - level 3 always accesses directly.
`timescale 1ns/100ps
module vpmap_bank
  import vpmap_pkg::*;
#(
  parameter int unsigned HIGHEST_INDEX = 7
) (
  input  wire logic                             sys_clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             acc_valid_i,
  input  wire logic                             acc_write_i,
  input  wire logic [15:0]                      acc_enc_i,
  input  wire logic [vpmap_pkg::VPMAP_DATA_W-1:0] acc_wdata_i,
  input  wire logic [1:0]                       cur_level_i,
  input  wire logic                             level2_enabled_i,
  input  wire logic                             nested_virt_enable_i,
  input  wire logic                             nested_virt_redirect_i,
  input  wire logic                             trap_lower_levels_i,
  input  wire logic                             level1_map_enable_i,
  input  wire logic                             level0_map_enable_i,
  input  wire logic [15:0]                      level1_partition_id_i,
  input  wire logic [15:0]                      level0_partition_id_i,
  output logic                                  acc_hit_o,
  output vpmap_pkg::vpmap_result_t              acc_result_o,
  output logic [vpmap_pkg::VPMAP_DATA_W-1:0]    acc_rdata_o,
  output logic [11:0]                           acc_mem_offset_o,
  output logic [1:0]                            trap_level_o,
  output logic [5:0]                            trap_class_o,
  output logic [2:0]                            highest_map_reg_index_o,
  output logic [15:0]                           level1_phys_id_o,
  output logic [15:0]                           level0_phys_id_o
);
  import vpmap_pkg::*;

  localparam int unsigned NREGS = HIGHEST_INDEX + 1;

  typedef struct packed {
    logic [VPMAP_VALID_W-1:0]                    valid;
    logic [VPMAP_MAX_REGS-1:0][VPMAP_DATA_W-1:0] entries;
    logic [VPMAP_DATA_W-1:0]                     rdata;
  } vpmap_state_t;

  vpmap_state_t st_r;
  vpmap_state_t st_nxt;

  logic        is_valid_reg;
  logic        is_entry_reg;
  logic [2:0]  reg_sel;
  logic        reg_impl;
  logic        do_direct;
  logic [4:0]  implemented;
  logic        map_active;
  logic        nv_redirect;
  logic        nv_trap;
  logic [VPMAP_MAX_REGS-1:0]                   reg_present;
  logic [VPMAP_MAX_REGS-1:0][VPMAP_DATA_W-1:0] map_view;
  logic [VPMAP_VALID_W-1:0]                    valid_view;

  assign highest_map_reg_index_o = 3'(HIGHEST_INDEX);
  // highest implemented entry
  // The last entry index is carried, not the count, since a full bank of 32 entries does not fit five bits.
  assign implemented = 5'(NREGS * VPMAP_ENTRIES_PER - 1);

  // absent registers masked
  // Flops for all eight registers exist; the parameter only trims decode and translation, not area.
  always_comb begin
    for (int r = 0; r < VPMAP_MAX_REGS; r++) begin
      reg_present[r] = 32'(r) <= HIGHEST_INDEX;
      map_view[r]    = reg_present[r] ? st_r.entries[r] : '0;
      valid_view[r*VPMAP_ENTRIES_PER +: VPMAP_ENTRIES_PER] =
        reg_present[r] ? st_r.valid[r*VPMAP_ENTRIES_PER +: VPMAP_ENTRIES_PER] : '0;
    end
  end

  always_comb begin
    is_valid_reg = acc_enc_i == VPMAP_ENC_VALID;
    reg_sel      = acc_enc_i[2:0];
    reg_impl     = reg_present[reg_sel];
    is_entry_reg = ((acc_enc_i & VPMAP_ENC_ENTRY_MSK) == VPMAP_ENC_ENTRY0) && reg_impl;
    acc_hit_o    = acc_valid_i && (is_valid_reg || is_entry_reg);
    // Both nested controls must be set to redirect; the enable alone only traps.
    nv_redirect  = level2_enabled_i && nested_virt_enable_i && nested_virt_redirect_i;
    nv_trap      = level2_enabled_i && nested_virt_enable_i && !nested_virt_redirect_i;
    acc_result_o     = VPMAP_RES_UNDEF;
    acc_mem_offset_o = 12'h000;
    trap_level_o     = VPMAP_LEVEL2;
    trap_class_o     = 6'h00;
    unique case (cur_level_i)
      VPMAP_LEVEL0: begin
        acc_result_o = VPMAP_RES_UNDEF;
      end
      VPMAP_LEVEL1: begin
        if (nv_redirect) begin
          acc_result_o     = VPMAP_RES_MEMORY;
          acc_mem_offset_o = is_valid_reg ? VPMAP_NV_OFS_VALID
                                          : VPMAP_NV_OFS_ENTRY0 + 12'(reg_sel) * VPMAP_NV_OFS_STEP;
        end else if (nv_trap) begin
          acc_result_o = VPMAP_RES_TRAP;
          trap_class_o = VPMAP_TRAP_CLASS;
          trap_level_o = trap_lower_levels_i ? VPMAP_LEVEL3 : VPMAP_LEVEL2;
        end else begin
          acc_result_o = VPMAP_RES_UNDEF;
        end
      end
      VPMAP_LEVEL2: begin
        if (trap_lower_levels_i) begin
          acc_result_o = VPMAP_RES_TRAP;
          trap_class_o = VPMAP_TRAP_CLASS;
          trap_level_o = VPMAP_LEVEL3;
        end else begin
          acc_result_o = VPMAP_RES_DIRECT;
        end
      end
      VPMAP_LEVEL3: begin
        acc_result_o = VPMAP_RES_DIRECT;
      end
    endcase
    do_direct = acc_hit_o && (acc_result_o == VPMAP_RES_DIRECT);
  end

  always_comb begin
    st_nxt = st_r;
    if (do_direct && acc_write_i) begin
      if (is_valid_reg) begin
        st_nxt.valid = acc_wdata_i[VPMAP_VALID_W-1:0];
      end else begin
        st_nxt.entries[reg_sel] = acc_wdata_i;
      end
    end
    if (do_direct && !acc_write_i) begin
      st_nxt.rdata = is_valid_reg ? {32'h0000_0000, st_r.valid} : st_r.entries[reg_sel];
    end
    if (rst_i) begin
      // contents not cleared, and a direct write in the same cycle still lands; only read data cleared so outputs are defined.
      st_nxt.rdata = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st_r <= st_nxt;
  end

  assign acc_rdata_o = st_r.rdata;

  // no effect unless level 2 enabled
  assign map_active = level2_enabled_i;

  // entry m sits in register m>>2, flattened in order.
  vpmap_lookup #(
    .ENTRIES (VPMAP_NUM_VALID),
    .ID_W    (VPMAP_ENTRY_W)
  ) u_lookup_l1 (
    .virt_id_i     (level1_partition_id_i),
    .map_enable_i  (map_active && level1_map_enable_i),
    .map_i         (map_view),
    .valid_i       (valid_view),
    .implemented_i (implemented),
    .phys_id_o     (level1_phys_id_o),
    .hit_o         ()
  );

  // level 0 has its own enable
  vpmap_lookup #(
    .ENTRIES (VPMAP_NUM_VALID),
    .ID_W    (VPMAP_ENTRY_W)
  ) u_lookup_l0 (
    .virt_id_i     (level0_partition_id_i),
    .map_enable_i  (map_active && level0_map_enable_i),
    .map_i         (map_view),
    .valid_i       (valid_view),
    .implemented_i (implemented),
    .phys_id_o     (level0_phys_id_o),
    .hit_o         ()
  );
endmodule

// >>> tb/vpmap_bank_properties.sv
// Port-level assertions for the partition-id map bank.
// Assumes it is bound onto vpmap_bank and given the same HIGHEST_INDEX.
`timescale 1ns/100ps
module vpmap_bank_props
  import vpmap_pkg::*;
#(parameter int unsigned HIGHEST_INDEX = 7) (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire logic                 acc_valid_i,
  input wire logic                 acc_write_i,
  input wire logic [15:0]          acc_enc_i,
  input wire logic [63:0]          acc_wdata_i,
  input wire logic [1:0]           cur_level_i,
  input wire logic                 level2_enabled_i,
  input wire logic                 nested_virt_enable_i,
  input wire logic                 nested_virt_redirect_i,
  input wire logic                 trap_lower_levels_i,
  input wire logic                 level1_map_enable_i,
  input wire logic [15:0]          level1_partition_id_i,
  input wire logic                 acc_hit_o,
  input wire vpmap_pkg::vpmap_result_t acc_result_o,
  input wire logic [63:0]          acc_rdata_o,
  input wire logic [11:0]          acc_mem_offset_o,
  input wire logic [1:0]           trap_level_o,
  input wire logic [5:0]           trap_class_o,
  input wire logic [2:0]           highest_map_reg_index_o,
  input wire logic [15:0]          level1_phys_id_o
);
  import vpmap_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic l1 = acc_hit_o && cur_level_i == VPMAP_LEVEL1 && level2_enabled_i;
  wire logic vrd = acc_valid_i && !acc_write_i && acc_enc_i == VPMAP_ENC_VALID && acc_result_o == VPMAP_RES_DIRECT;
  wire logic vwr = acc_valid_i && acc_write_i && acc_enc_i == VPMAP_ENC_VALID && acc_result_o == VPMAP_RES_DIRECT;
  chk_lvl0_undef: assert property (acc_hit_o && cur_level_i == VPMAP_LEVEL0 |-> acc_result_o == VPMAP_RES_UNDEF)
    else $error("level 0 access not undefined");
  chk_nv_redirect: assert property (l1 && nested_virt_enable_i && nested_virt_redirect_i && acc_enc_i == VPMAP_ENC_VALID
    |-> acc_result_o == VPMAP_RES_MEMORY && acc_mem_offset_o == 12'h938) else $error("redirect wrong");
  chk_nv_trap: assert property (l1 && nested_virt_enable_i && !nested_virt_redirect_i |-> acc_result_o == VPMAP_RES_TRAP
    && trap_class_o == 6'h18 && trap_level_o == (trap_lower_levels_i ? 2'h3 : 2'h2)) else $error("level 1 trap wrong");
  chk_l1_undef: assert property (acc_hit_o && cur_level_i == VPMAP_LEVEL1 && !(level2_enabled_i && nested_virt_enable_i)
    |-> acc_result_o == VPMAP_RES_UNDEF) else $error("level 1 access not undefined");
  chk_l2_gate: assert property (acc_hit_o && cur_level_i == VPMAP_LEVEL2
    |-> acc_result_o == (trap_lower_levels_i ? VPMAP_RES_TRAP : VPMAP_RES_DIRECT)) else $error("level 2 outcome wrong");
  chk_l3_direct: assert property (acc_hit_o && cur_level_i == VPMAP_LEVEL3 |-> acc_result_o == VPMAP_RES_DIRECT)
    else $error("level 3 access not direct");
  chk_rd_upper: assert property (vrd |=> acc_rdata_o[63:32] == 32'h0)
    else $error("valid register upper half not zero");
  chk_wr_readback: assert property (vwr ##1 vrd |=> acc_rdata_o[31:0] == $past(acc_wdata_i[31:0], 2))
    else $error("valid register readback wrong");
  chk_index_field: assert property (highest_map_reg_index_o == 3'(HIGHEST_INDEX))
    else $error("highest index field wrong");
  chk_no_level2: assert property (!level2_enabled_i |-> level1_phys_id_o == level1_partition_id_i)
    else $error("mapping active without level 2");
  chk_l1_disabled: assert property (!level1_map_enable_i |-> level1_phys_id_o == level1_partition_id_i)
    else $error("mapping active while disabled");
endmodule

// >>> tb/tb_vpmap_bank.sv
// Self-checking bench for the partition-id map bank.
// Assumes one access per cycle; inputs change on the falling edge.
`timescale 1ns/100ps
module tb_vpmap_bank;
  import vpmap_pkg::*;
  logic          sys_clk_i, rst_i, acc_valid_i, acc_write_i, level2_enabled_i, nested_virt_enable_i;
  logic          nested_virt_redirect_i, trap_lower_levels_i, level1_map_enable_i, level0_map_enable_i, acc_hit_o;
  logic [1:0]    cur_level_i, trap_level_o;
  logic [15:0]   acc_enc_i, level1_partition_id_i, level0_partition_id_i, level1_phys_id_o, level0_phys_id_o;
  logic [63:0]   acc_wdata_i, acc_rdata_o;
  logic [11:0]   acc_mem_offset_o;
  logic [5:0]    trap_class_o;
  logic [2:0]    highest_map_reg_index_o;
  vpmap_result_t acc_result_o;
  int            failures, check_count;
  vpmap_bank #(.HIGHEST_INDEX(7)) vpmap_bank_inst (.*);
  task cmp(input string n, input logic [63:0] e, input logic [63:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The request is held over exactly one rising edge; the result is combinational.
  task acc(input logic w, input logic [1:0] lv, input logic [2:0] c, input logic [15:0] e, input logic [63:0] d,
           input vpmap_result_t r);
    @(negedge sys_clk_i);
    {acc_valid_i, acc_write_i, cur_level_i, acc_enc_i, acc_wdata_i} = {1'b1, w, lv, e, d};
    {nested_virt_enable_i, nested_virt_redirect_i, trap_lower_levels_i} = c;
    #1 cmp("result", 64'(r), 64'(acc_result_o));
  endtask
  task idle;
    @(negedge sys_clk_i);
    acc_valid_i = 1'b0;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (500) @(posedge sys_clk_i);
    failures++;
    stop_test;
  end
  initial begin
    {rst_i, acc_valid_i, acc_write_i, nested_virt_enable_i, nested_virt_redirect_i, trap_lower_levels_i} = 6'h20;
    {level2_enabled_i, level1_map_enable_i, level0_map_enable_i, cur_level_i, acc_enc_i} = {3'h7, 2'h3, 16'h0};
    {acc_wdata_i, level1_partition_id_i, level0_partition_id_i} = '0;
    repeat (6) @(negedge sys_clk_i);
    rst_i = 1'b0;
    acc(1, 3, 3'h0, VPMAP_ENC_VALID, 64'hFFFF_FFFF_0000_0022, VPMAP_RES_DIRECT);
    cmp("hit", 64'h1, 64'(acc_hit_o));
    acc(0, 3, 3'h0, VPMAP_ENC_VALID, 64'h0, VPMAP_RES_DIRECT);
    acc(1, 2, 3'h1, VPMAP_ENC_VALID, 64'h0, VPMAP_RES_TRAP);
    cmp("trap_level", 64'h3, 64'(trap_level_o));
    cmp("rdata", 64'h22, acc_rdata_o);
    acc(0, 2, 3'h0, VPMAP_ENC_VALID, 64'h0, VPMAP_RES_DIRECT);
    acc(0, 1, 3'h6, VPMAP_ENC_VALID, 64'h0, VPMAP_RES_MEMORY);
    cmp("mem_offset", 64'h938, 64'(acc_mem_offset_o));
    cmp("rdata_kept", 64'h22, acc_rdata_o);
    acc(0, 1, 3'h4, VPMAP_ENC_VALID, 64'h0, VPMAP_RES_TRAP);
    cmp("trap_level", 64'h2, 64'(trap_level_o));
    cmp("trap_class", 64'h18, 64'(trap_class_o));
    acc(0, 1, 3'h5, VPMAP_ENC_VALID, 64'h0, VPMAP_RES_TRAP);
    cmp("trap_level", 64'h3, 64'(trap_level_o));
    acc(0, 1, 3'h0, VPMAP_ENC_VALID, 64'h0, VPMAP_RES_UNDEF);
    acc(1, 0, 3'h6, VPMAP_ENC_VALID, 64'h0, VPMAP_RES_UNDEF);
    acc(1, 3, 3'h0, VPMAP_ENC_ENTRY0, 64'h0044_0033_0022_0011, VPMAP_RES_DIRECT);
    acc(1, 3, 3'h0, VPMAP_ENC_ENTRY0 + 16'h1, 64'h0088_0077_0066_0055, VPMAP_RES_DIRECT);
    acc(0, 3, 3'h0, VPMAP_ENC_ENTRY0 + 16'h1, 64'h0, VPMAP_RES_DIRECT);
    acc(1, 1, 3'h6, VPMAP_ENC_ENTRY0 + 16'h1, 64'h0, VPMAP_RES_MEMORY);
    cmp("mem_offset_map", 64'h948, 64'(acc_mem_offset_o));
    cmp("rdata_map", 64'h0088_0077_0066_0055, acc_rdata_o);
    acc(1, 3, 3'h0, 16'hE522, 64'h0, VPMAP_RES_DIRECT);
    cmp("hit_foreign", 64'h0, 64'(acc_hit_o));
    idle;
    {level1_partition_id_i, level0_partition_id_i} = {16'h5, 16'h1};
    #1 cmp("l1_phys", 64'h66, 64'(level1_phys_id_o));
    cmp("l0_phys", 64'h22, 64'(level0_phys_id_o));
    @(negedge sys_clk_i) level0_partition_id_i = 16'h0;
    #1 cmp("l0_invalid", 64'h0, 64'(level0_phys_id_o));
    @(negedge sys_clk_i) level1_map_enable_i = 1'b0;
    @(negedge sys_clk_i) cmp("l1_off", 64'h5, 64'(level1_phys_id_o));
    {level1_map_enable_i, level2_enabled_i} = 2'b10;
    @(negedge sys_clk_i) cmp("no_level2", 64'h5, 64'(level1_phys_id_o));
    cmp("max_index", 64'h7, 64'(highest_map_reg_index_o));
    stop_test;
  end
endmodule
bind vpmap_bank vpmap_bank_props #(.HIGHEST_INDEX(HIGHEST_INDEX)) vpmap_bank_props_inst (.*);
